// ---- lcsc_consts.svh ----
// Constants of the link channel and sync-header configuration registers.
`ifndef LCSC_CONSTS_SVH
`define LCSC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define LCSC_IDX_PAIR_ENABLE   10'h209
`define LCSC_IDX_HEADER_SELECT 10'h20f
`define LCSC_IDX_REQ_THRESH    10'h210
`define LCSC_IDX_LINK_GEOMETRY 10'h220
`define LCSC_IDX_LINK_CONTROL  10'h221
`define LCSC_IDX_LINK_STATUS   10'h222

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define LCSC_BIT_LOWER_PAIR    0
`define LCSC_BIT_UPPER_PAIR    1
`define LCSC_BIT_SINGLE_MODE   2
`define LCSC_BIT_LINK_ENABLE   0
`define LCSC_BIT_MODE_64B66B   1

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define LCSC_RST_PAIR_ENABLE   3'h3
`define LCSC_RST_HEADER_SELECT 2'h0
`define LCSC_RST_REQ_THRESH    5'h03
`define LCSC_RST_FULL_LANES    4'h8
`define LCSC_RST_FULL_CONVS    4'h4
`define LCSC_RST_LINK_CONTROL  2'h0

`endif

// ---- lcsc_pkg.sv ----
// Types shared by the link channel and sync-header configuration block.
package lcsc_pkg;

   // -------------------------------------------------------------------------
   // State machines and codes.
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      bus_idle = 2'h0,
      bus_done = 2'h1
   } lcsc_bus_e;

   typedef enum logic [1:0] {
      sy_idle    = 2'h0,
      sy_count   = 2'h1,
      sy_request = 2'h3
   } lcsc_sync_e;

   typedef enum logic [1:0] {
      sh_crc12 = 2'h0,
      sh_rsvd1 = 2'h1,
      sh_fec   = 2'h2,
      sh_rsvd3 = 2'h3
   } lcsc_shsel_e;

   // -------------------------------------------------------------------------
   // Carriers.
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [11:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } lcsc_av_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } lcsc_av_rsp_s;

   typedef struct packed {
      logic [3:0] chan_on;
      logic [3:0] lane_count;
      logic [3:0] conv_count;
      logic       tail_pad;
      logic       pair_swap;
   } lcsc_geom_s;

endpackage : lcsc_pkg

// ---- lcsc_sync_detect.sv ----
// Synchronisation request detector for the active-low sync line.
`timescale 1ns/1ps
`default_nettype none
module lcsc_sync_detect (
   input  wire logic       clock,       // Link clock.
   input  wire logic       rst_n,       // Asynchronous reset, active low.
   input  wire logic       sync_n,      // Sync line pin, active low.
   input  wire logic [4:0] thresh,      // Request threshold.
   output logic            sync_req,    // Request level, from a flop.
   output logic            sync_high    // Synchronised line level.
);

   typedef struct packed {
      logic                meta;
      logic                sync_s;
      lcsc_pkg::lcsc_sync_e st;
      logic [5:0]          cnt;
      logic                req;
   } lcsc_sd_s;

   lcsc_sd_s q;
   lcsc_sd_s d;

   always_comb begin
      d        = q;
      d.meta   = sync_n;
      d.sync_s = q.meta;
      if (q.sync_s) begin
         d.st  = lcsc_pkg::sy_idle;
         d.cnt = 6'h00;
         d.req = 1'b0;
      end else if (q.st != lcsc_pkg::sy_request) begin
         d.cnt = q.cnt + 6'h01;
         // A shorter low run is an error report and leaves no trace.
         if (d.cnt == {1'b0, thresh} + 6'h01) begin
            d.st  = lcsc_pkg::sy_request;
            d.req = 1'b1;
         end else begin
            d.st = lcsc_pkg::sy_count;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{meta: 1'b1, sync_s: 1'b1, st: lcsc_pkg::sy_idle, cnt: 6'h00, req: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign sync_req  = q.req;
   assign sync_high = q.sync_s;

   default clocking sd_cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_req_after_lows: assert property ($rose(q.req) |-> q.cnt == {1'b0, thresh} + 6'h01)
      else $error("Sync request raised at the wrong low count.");
   a_high_clears_req: assert property (q.sync_s |=> !q.req)
      else $error("Sync request held while the line is high.");
   a_short_low_none: assert property (!q.sync_s && q.cnt < {1'b0, thresh} |=> !q.req)
      else $error("Sync request raised on a short low run.");
   c_sync_request: cover property ($rose(q.req));

endmodule : lcsc_sync_detect
`default_nettype wire

// ---- lcsc_top.sv ----
// Channel pair, sync-header and sync threshold configuration with Avalon-MM access.
`timescale 1ns/1ps
`default_nettype none
`include "lcsc_consts.svh"
module lcsc_top (
   input  wire logic                  clock,          // Link clock, 20 MHz.
   input  wire logic                  rst_n,          // Asynchronous reset, active low.
   input  wire lcsc_pkg::lcsc_av_req_s av_req,        // Avalon-MM request.
   output lcsc_pkg::lcsc_av_rsp_s     av_rsp,         // Avalon-MM response.
   input  wire logic                  sync_n,         // Sync line from receiver, active low.
   input  wire logic                  mb_start,       // Multiblock start pulse.
   input  wire logic [11:0]           crc_value,      // CRC-12 of the last multiblock.
   input  wire logic [25:0]           fec_value,      // FEC parity of the last multiblock.
   output lcsc_pkg::lcsc_geom_s       geom,           // Active channel and lane layout.
   output logic                       sync_request,   // Synchronisation request level.
   output lcsc_pkg::lcsc_shsel_e      payload_sel,    // Sync-header payload in use.
   output logic [31:0]                sh_word,        // Sync-header word per multiblock.
   output logic                       sh_valid,       // Pulse with each header word.
   output logic                       link_enable,    // Link enable bit.
   output logic                       mode_64b66b     // Link mode selects 64B/66B.
);

   // -------------------------------------------------------------------------
   // State.
   // -------------------------------------------------------------------------
   typedef struct packed {
      lcsc_pkg::lcsc_bus_e   bus;
      lcsc_pkg::lcsc_av_rsp_s rsp;
      logic [2:0]            pair_en;
      logic [1:0]            shsel;
      logic [4:0]            thresh;
      logic [3:0]            full_lanes;
      logic [3:0]            full_convs;
      logic [1:0]            ctl;
      lcsc_pkg::lcsc_geom_s  geom;
      lcsc_pkg::lcsc_shsel_e psel;
      logic [31:0]           sh_word;
      logic                  sh_valid;
   } lcsc_top_s;

   lcsc_top_s q;
   lcsc_top_s d;

   logic sd_req;
   logic sd_high;

   // -------------------------------------------------------------------------
   // Helpers.
   // -------------------------------------------------------------------------
   function automatic logic lcsc_hit(input logic [11:0] addr, input logic [9:0] idx);
      lcsc_hit = (addr[11:2] == idx);
   endfunction : lcsc_hit

   function automatic lcsc_pkg::lcsc_geom_s lcsc_layout(
      input logic [2:0] pe,
      input logic [3:0] fl,
      input logic [3:0] fc
   );
      lcsc_pkg::lcsc_geom_s g;
      logic                 lower;
      logic                 upper;
      logic                 single;
      logic                 reduced;
      logic [4:0]           half_up;
      lower   = pe[`LCSC_BIT_LOWER_PAIR];
      upper   = pe[`LCSC_BIT_UPPER_PAIR];
      single  = pe[`LCSC_BIT_SINGLE_MODE];
      half_up = ({1'b0, fl} + 5'h01) >> 1;
      if (single) begin
         g.chan_on = 4'b0001;
      end else begin
         g.chan_on = {upper, upper, lower, lower};
      end
      // Both pairs off is undefined; the full lane and converter counts are kept then, with no channel on.
      reduced      = single | (lower ^ upper);
      g.lane_count = reduced ? half_up[3:0] : fl;
      g.conv_count = reduced ? {1'b0, fc[3:1]} : fc;
      g.tail_pad   = reduced & fl[0];
      g.pair_swap  = !single & !lower & upper;
      lcsc_layout  = g;
   endfunction : lcsc_layout

   function automatic logic [7:0] lcsc_read(input logic [11:0] addr, input lcsc_top_s s,
                                            input logic req, input logic high);
      lcsc_read = 8'h00;
      if (lcsc_hit(addr, `LCSC_IDX_PAIR_ENABLE)) begin
         lcsc_read = {5'h00, s.pair_en};
      end else if (lcsc_hit(addr, `LCSC_IDX_HEADER_SELECT)) begin
         lcsc_read = {6'h00, s.shsel};
      end else if (lcsc_hit(addr, `LCSC_IDX_REQ_THRESH)) begin
         lcsc_read = {3'h0, s.thresh};
      end else if (lcsc_hit(addr, `LCSC_IDX_LINK_GEOMETRY)) begin
         lcsc_read = {s.full_convs, s.full_lanes};
      end else if (lcsc_hit(addr, `LCSC_IDX_LINK_CONTROL)) begin
         lcsc_read = {6'h00, s.ctl};
      end else if (lcsc_hit(addr, `LCSC_IDX_LINK_STATUS)) begin
         lcsc_read = {s.geom.chan_on, 2'h0, req, high};
      end
   endfunction : lcsc_read

   // -------------------------------------------------------------------------
   // Sync request detection.
   // -------------------------------------------------------------------------
   lcsc_sync_detect u_sync (
      .clock     (clock),
      .rst_n     (rst_n),
      .sync_n    (sync_n),
      .thresh    (q.thresh),
      .sync_req  (sd_req),
      .sync_high (sd_high)
   );

   // -------------------------------------------------------------------------
   // Next state.
   // -------------------------------------------------------------------------
   always_comb begin
      d                 = q;
      d.rsp.waitrequest = 1'b1;
      case (q.bus)
         lcsc_pkg::bus_idle: begin
            // One wait state: the answer is always ready on the next edge.
            if (av_req.read || av_req.write) begin
               d.bus             = lcsc_pkg::bus_done;
               d.rsp.waitrequest = 1'b0;
               d.rsp.readdata    = 32'h0000_0000;
               if (av_req.read) begin
                  d.rsp.readdata = {24'h00_0000, lcsc_read(av_req.address, q, sd_req, sd_high)};
               end
            end
         end
         lcsc_pkg::bus_done: begin
            d.bus = lcsc_pkg::bus_idle;
            // A write lands only at the edge where the master sees waitrequest low.
            // Reserved bits are dropped here and read back as zero.
            if (av_req.write) begin
               if (lcsc_hit(av_req.address, `LCSC_IDX_PAIR_ENABLE)) begin
                  d.pair_en = av_req.writedata[2:0];
               end
               if (lcsc_hit(av_req.address, `LCSC_IDX_HEADER_SELECT)) begin
                  d.shsel = av_req.writedata[1:0];
               end
               if (lcsc_hit(av_req.address, `LCSC_IDX_REQ_THRESH)) begin
                  d.thresh = av_req.writedata[4:0];
               end
               if (lcsc_hit(av_req.address, `LCSC_IDX_LINK_GEOMETRY)) begin
                  d.full_lanes = av_req.writedata[3:0];
                  d.full_convs = av_req.writedata[7:4];
               end
               if (lcsc_hit(av_req.address, `LCSC_IDX_LINK_CONTROL)) begin
                  d.ctl = av_req.writedata[1:0];
               end
            end
         end
         default: begin
            d.bus = lcsc_pkg::bus_idle;
         end
      endcase

      // The layout lags the registers by one cycle, which is harmless while the link is off.
      d.geom = lcsc_layout(q.pair_en, q.full_lanes, q.full_convs);

      // The header select only steers the link while 64B/66B is chosen.
      d.psel = lcsc_pkg::lcsc_shsel_e'(q.shsel);
      if (!q.ctl[`LCSC_BIT_MODE_64B66B]) begin
         d.psel = lcsc_pkg::sh_crc12;
      end

      d.sh_valid = 1'b0;
      if (mb_start && q.ctl[`LCSC_BIT_LINK_ENABLE] && q.ctl[`LCSC_BIT_MODE_64B66B]) begin
         d.sh_valid = 1'b1;
         case (lcsc_pkg::lcsc_shsel_e'(q.shsel))
            lcsc_pkg::sh_crc12: begin
               d.sh_word = {20'h0_0000, crc_value};
            end
            lcsc_pkg::sh_fec: begin
               d.sh_word = {6'h00, fec_value};
            end
            default: begin
               d.sh_word = 32'h0000_0000;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Registers.
   // -------------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q.bus             <= lcsc_pkg::bus_idle;
         q.rsp.readdata    <= 32'h0000_0000;
         q.rsp.waitrequest <= 1'b1;
         q.pair_en         <= `LCSC_RST_PAIR_ENABLE;
         q.shsel           <= `LCSC_RST_HEADER_SELECT;
         q.thresh          <= `LCSC_RST_REQ_THRESH;
         q.full_lanes      <= `LCSC_RST_FULL_LANES;
         q.full_convs      <= `LCSC_RST_FULL_CONVS;
         q.ctl             <= `LCSC_RST_LINK_CONTROL;
         q.geom            <= '{chan_on: 4'hf, lane_count: `LCSC_RST_FULL_LANES,
                                conv_count: `LCSC_RST_FULL_CONVS, tail_pad: 1'b0, pair_swap: 1'b0};
         q.psel            <= lcsc_pkg::sh_crc12;
         q.sh_word         <= 32'h0000_0000;
         q.sh_valid        <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs.
   // -------------------------------------------------------------------------
   assign av_rsp       = q.rsp;
   assign geom         = q.geom;
   assign sync_request = sd_req;
   assign payload_sel  = q.psel;
   assign sh_word      = q.sh_word;
   assign sh_valid     = q.sh_valid;
   assign link_enable  = q.ctl[`LCSC_BIT_LINK_ENABLE];
   assign mode_64b66b  = q.ctl[`LCSC_BIT_MODE_64B66B];

   // -------------------------------------------------------------------------
   // Checks.
   // -------------------------------------------------------------------------
   default clocking top_cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_single_only_a: assert property ($past(q.pair_en[2]) |-> q.geom.chan_on == 4'b0001)
      else $error("Single mode left more than channel A on.");

   a_upper_pair_map: assert property (!$past(q.pair_en[2])
         |-> q.geom.chan_on[3:2] == {2{$past(q.pair_en[1])}})
      else $error("Channels C and D do not follow the upper pair bit.");

   a_lower_pair_map: assert property (!$past(q.pair_en[2])
         |-> q.geom.chan_on[1:0] == {2{$past(q.pair_en[0])}})
      else $error("Channels A and B do not follow the lower pair bit.");

   a_half_lanes_convs: assert property ($past(q.pair_en) == 3'b001 |->
         q.geom.lane_count == 4'(({1'b0, $past(q.full_lanes)} + 5'h01) >> 1)
         && q.geom.conv_count == ($past(q.full_convs) >> 1))
      else $error("Reduced layout has wrong lane or converter count.");

   a_tail_pad_odd: assert property ($past(q.pair_en) == 3'b010 |->
         q.geom.tail_pad == $past(q.full_lanes[0]))
      else $error("Tail padding does not match the odd lane count.");

   a_swap_when_lower: assert property ($past(q.pair_en) == 3'b010 |-> q.geom.pair_swap)
      else $error("Upper pair samples not moved into lower slots.");

   a_header_64b_only: assert property (q.sh_valid |-> $past(q.ctl) == 2'h3 && $past(mb_start))
      else $error("Sync-header word sent outside 64B/66B link.");

   a_cmd_idle_bits: assert property (q.sh_valid && $past(q.shsel) == 2'h0
         |-> q.sh_word[31:12] == 20'h0_0000 && q.sh_word[11:0] == $past(crc_value))
      else $error("CRC header word carries non-idle command bits.");

   a_fec_word: assert property (q.sh_valid && $past(q.shsel) == 2'h2
         |-> q.sh_word == {6'h00, $past(fec_value)})
      else $error("FEC header word is wrong.");

   a_wait_one_cycle: assert property ((av_req.read || av_req.write) && q.bus == lcsc_pkg::bus_idle
         |=> !q.rsp.waitrequest ##1 q.rsp.waitrequest)
      else $error("Wait request not low for exactly one cycle.");

   // -------------------------------------------------------------------------
   // Layout and header checks.
   // -------------------------------------------------------------------------
   a_psel_plain_crc: assert property (!$past(q.ctl[`LCSC_BIT_MODE_64B66B])
         |-> q.psel == lcsc_pkg::sh_crc12)
      else $error("Header select steers a link that is not 64B/66B.");

   a_psel_follows: assert property ($past(q.ctl[`LCSC_BIT_MODE_64B66B])
         |-> q.psel == $past(q.shsel))
      else $error("Payload in use differs from the header select.");

   a_rsvd_word_zero: assert property (q.sh_valid && $past(q.shsel[0])
         |-> q.sh_word == 32'h0000_0000)
      else $error("Reserved header select sent a non-zero word.");

   a_fec_cmd_idle: assert property (q.sh_valid && $past(q.shsel) == 2'h2
         |-> q.sh_word[31:26] == 6'h00)
      else $error("FEC header word carries non-idle command bits.");

   a_single_counts: assert property ($past(q.pair_en[2])
         |-> q.geom.conv_count == ($past(q.full_convs) >> 1) && !q.geom.pair_swap)
      else $error("Single mode layout has wrong counts or swap.");

   a_upper_off_tail: assert property ($past(q.pair_en) == 3'b001
         |-> q.geom.tail_pad == $past(q.full_lanes[0]) && !q.geom.pair_swap)
      else $error("Upper pair off gives wrong tail or swap.");

   a_full_layout: assert property ($past(q.pair_en) == 3'b011
         |-> q.geom.lane_count == $past(q.full_lanes)
         && q.geom.conv_count == $past(q.full_convs) && !q.geom.tail_pad)
      else $error("Full layout does not keep the full counts.");

   a_swap_needs_upper: assert property (q.geom.pair_swap
         |-> $past(q.pair_en) == 3'b010)
      else $error("Pair swap raised without the upper pair alone.");

   a_tail_even_none: assert property (!$past(q.full_lanes[0])
         |-> !q.geom.tail_pad)
      else $error("Tail padding with an even full lane count.");

   // -------------------------------------------------------------------------
   // Register bus checks.
   // -------------------------------------------------------------------------
   a_read_high_zero: assert property (!q.rsp.waitrequest
         |-> q.rsp.readdata[31:8] == 24'h00_0000)
      else $error("Read data carries bits above the register byte.");

   a_idle_no_write: assert property (q.bus == lcsc_pkg::bus_idle
         |=> $stable(q.pair_en) && $stable(q.shsel) && $stable(q.thresh))
      else $error("Register changed outside an acknowledged write.");

   a_pair_write_lands: assert property (q.bus == lcsc_pkg::bus_done && av_req.write
         && lcsc_hit(av_req.address, `LCSC_IDX_PAIR_ENABLE)
         |=> q.pair_en == $past(av_req.writedata[2:0]))
      else $error("Pair enable write did not land.");

   a_sel_write_lands: assert property (q.bus == lcsc_pkg::bus_done && av_req.write
         && lcsc_hit(av_req.address, `LCSC_IDX_HEADER_SELECT)
         |=> q.shsel == $past(av_req.writedata[1:0]))
      else $error("Header select write did not land.");

   a_thresh_write_lands: assert property (q.bus == lcsc_pkg::bus_done && av_req.write
         && lcsc_hit(av_req.address, `LCSC_IDX_REQ_THRESH)
         |=> q.thresh == $past(av_req.writedata[4:0]))
      else $error("Threshold write did not land.");

   a_status_chan: assert property (q.bus == lcsc_pkg::bus_idle && av_req.read
         && lcsc_hit(av_req.address, `LCSC_IDX_LINK_STATUS)
         |=> q.rsp.readdata[7:4] == $past(q.geom.chan_on))
      else $error("Status read does not show the channel enables.");

   c_single_mode: cover property (q.geom.chan_on == 4'b0001);
   c_pair_swap:   cover property (q.geom.pair_swap && q.geom.tail_pad);
   c_fec_word:    cover property (q.sh_valid && q.psel == lcsc_pkg::sh_fec);
   c_write_done:  cover property (q.bus == lcsc_pkg::bus_done && av_req.write);

endmodule : lcsc_top
`default_nettype wire

// ---- lcsc_rx_model.sv ----
// Behavioural far-side receiver that drives the active-low sync line.
`timescale 1ns/1ps
`default_nettype none
module lcsc_rx_model (
   input  wire logic       clock,    // Link clock.
   input  wire logic       rst_n,    // Asynchronous reset, active low.
   input  wire logic       go,       // Starts one low run of the sync line.
   input  wire logic [7:0] len,      // Length of the low run in clock cycles.
   output logic            sync_n    // Sync line, active low.
);
   // -------------------------------------------------------------------------
   // Low-run generator.
   // -------------------------------------------------------------------------
   logic [7:0] left_q;

   // The line has a pull-up, so it returns high when no run is in progress.
   // A run no longer than the threshold stands for an error report.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_n <= 1'b1;
         left_q <= 8'h00;
      end else if (go) begin
         sync_n <= 1'b0;
         left_q <= len - 8'h01;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end else begin
         sync_n <= 1'b1;
      end
   end
endmodule : lcsc_rx_model
`default_nettype wire

// ---- tb_link_channel_sync_config.sv ----
// Self-checking testbench of the channel pair and sync-header configuration block.
`timescale 1ns/1ps
`default_nettype none
module tb_link_channel_sync_config;
   // -------------------------------------------------------------------------
   // Signals and stimulus table.
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] geo;
      logic [7:0] pe;
      logic [3:0] chan;
      logic [3:0] lanes;
      logic [3:0] convs;
      logic       tail;
      logic       swap;
   } lcsc_row_s;

   logic                    clock, rst_n, mb_start, go, sync_n, sync_request, sh_valid;
   logic                    link_enable, mode_64b66b;
   logic [11:0]             crc_value;
   logic [25:0]             fec_value;
   logic [7:0]              len;
   logic [31:0]             sh_word, q, exp_w;
   lcsc_pkg::lcsc_av_req_s  av_req;
   lcsc_pkg::lcsc_av_rsp_s  av_rsp;
   lcsc_pkg::lcsc_geom_s    geom;
   lcsc_pkg::lcsc_shsel_e   payload_sel;
   int                      failures, n_checks, cycles, first;
   lcsc_row_s               rows [7] = '{
      '{8'h48, 8'h03, 4'hf, 4'h8, 4'h4, 1'b0, 1'b0},
      '{8'h48, 8'h02, 4'hc, 4'h4, 4'h2, 1'b0, 1'b1},
      '{8'h48, 8'h01, 4'h3, 4'h4, 4'h2, 1'b0, 1'b0},
      '{8'h48, 8'h05, 4'h1, 4'h4, 4'h2, 1'b0, 1'b0},
      '{8'h47, 8'h01, 4'h3, 4'h4, 4'h2, 1'b1, 1'b0},
      '{8'h47, 8'h02, 4'hc, 4'h4, 4'h2, 1'b1, 1'b1},
      '{8'h47, 8'h03, 4'hf, 4'h7, 4'h4, 1'b0, 1'b0}};

   lcsc_top i_lcsc_top (
      .clock(clock), .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp), .sync_n(sync_n),
      .mb_start(mb_start), .crc_value(crc_value), .fec_value(fec_value), .geom(geom),
      .sync_request(sync_request), .payload_sel(payload_sel), .sh_word(sh_word),
      .sh_valid(sh_valid), .link_enable(link_enable), .mode_64b66b(mode_64b66b));

   lcsc_rx_model i_lcsc_rx_model (.clock(clock), .rst_n(rst_n), .go(go), .len(len), .sync_n(sync_n));

   always #25 clock = ~clock;

   // -------------------------------------------------------------------------
   // Shared tasks.
   // -------------------------------------------------------------------------
   task finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Avalon-MM access; the request is held until waitrequest is sampled low.
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      av_req <= '{address: a, read: !wr, write: wr, writedata: d};
      do begin
         @(posedge clock);
      end while (av_rsp.waitrequest !== 1'b0);
      q = av_rsp.readdata;
      av_req <= '0;
   endtask : bus

   task pulse_mb;
      @(posedge clock);
      crc_value <= 12'habc;
      fec_value <= 26'h2345678;
      mb_start <= 1'b1;
      @(posedge clock);
      mb_start <= 1'b0;
      #1;
   endtask : pulse_mb

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         finish_test;
      end
   end

   // -------------------------------------------------------------------------
   // Main sequence.
   // -------------------------------------------------------------------------
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      av_req = '0;
      mb_start = 1'b0;
      crc_value = 12'h000;
      fec_value = 26'h0;
      go = 1'b0;
      len = 8'h00;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, 12'h824, 32'h0);
      chk(q, 32'h3);
      bus(1'b0, 12'h83c, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 12'h840, 32'h0);
      chk(q, 32'h3);
      bus(1'b0, 12'h900, 32'h0);
      chk(q, 32'h0);
      // Link stays off while pairs change, one pair stays on, dual sets upper.
      foreach (rows[i]) begin
         bus(1'b1, 12'h880, {24'h0, rows[i].geo});
         bus(1'b1, 12'h824, {24'h0, rows[i].pe});
         bus(1'b0, 12'h824, 32'h0);
         chk(q, {29'h0, rows[i].pe[2:0]});
         chk({18'h0, geom}, {18'h0, rows[i].chan, rows[i].lanes, rows[i].convs, rows[i].tail, rows[i].swap});
      end
      // Select is only changed with the link disabled.
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 12'h884, 32'h0);
         bus(1'b1, 12'h83c, 32'(c));
         bus(1'b1, 12'h884, 32'h3);
         pulse_mb();
         exp_w = (c == 0) ? 32'h00000abc : (c == 2) ? 32'h02345678 : 32'h0;
         chk({31'h0, sh_valid}, 32'h1);
         chk(sh_word, exp_w);
         chk({30'h0, payload_sel}, 32'(c));
         chk({30'h0, mode_64b66b, link_enable}, 32'h3);
         @(posedge clock);
         #1;
         chk({31'h0, sh_valid}, 32'h0);
      end
      // Without 64B/66B encoding the header stream stays quiet.
      bus(1'b1, 12'h884, 32'h1);
      pulse_mb();
      chk({31'h0, sh_valid}, 32'h0);
      chk({30'h0, payload_sel}, 32'h0);
      chk({30'h0, mode_64b66b, link_enable}, 32'h1);
      bus(1'b1, 12'h884, 32'h0);
      bus(1'b1, 12'h840, 32'h2);
      // Threshold two: a run of two lows is an error report, three is a request.
      for (int l = 2; l < 4; l++) begin
         @(posedge clock);
         go <= 1'b1;
         len <= 8'(l);
         @(posedge clock);
         go <= 1'b0;
         first = 0;
         for (int k = 1; k <= 10; k++) begin
            @(posedge clock);
            #1;
            if (sync_request === 1'b1 && first == 0) begin
               first = k;
            end
         end
         chk(32'(first), (l == 3) ? 32'h5 : 32'h0);
      end
      bus(1'b0, 12'h888, 32'h0);
      chk(q, 32'hf1);
      // A reset in mid-run brings the layout registers back to their defaults.
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      bus(1'b0, 12'h880, 32'h0);
      chk(q, 32'h48);
      finish_test;
   end
endmodule : tb_link_channel_sync_config
`default_nettype wire
